// ### hdl/power_state_controller.v
// Power operating-state controller with AXI4-Lite register slave
`include "power_state_map.vh"
`timescale 1ns/1ps
`default_nettype none

module qual_timer (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       slow_tick,
  input  wire       level,
  output reg        qualified
);
  localparam integer LAST = `QUAL_TICKS - 1;
  reg [`QUAL_CNT_W-1:0] cnt_q;
  // Count slow ticks while asserted, restart on release
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q     <= {`QUAL_CNT_W{1'b0}};
      qualified <= 1'b0;
    end else if (!level) begin
      cnt_q     <= {`QUAL_CNT_W{1'b0}};
      qualified <= 1'b0;
    end else if (slow_tick && !qualified) begin
      if (cnt_q == LAST[`QUAL_CNT_W-1:0])
        qualified <= 1'b1;
      else
        cnt_q <= cnt_q + {{(`QUAL_CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

module power_state_controller (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        slow_tick,
  input  wire        power_key_in,
  input  wire        wake_request_gpio,
  input  wire        power_up_request_input,
  input  wire        hibernate_edge_gpio,
  input  wire        hibernate_level_gpio,
  input  wire        rtc_alarm,
  input  wire        adaptor_sense_above_4v0,
  input  wire        usb_above_4v0,
  input  wire [3:0]  line_level,
  input  wire        line_above_uvlo,
  input  wire        line_below_shutdown,
  input  wire        backup_supply_rail_ok,
  input  wire        shutdown_event,
  input  wire        fault_detected,
  input  wire        startup_seq_done,
  input  wire        startup_trigger,
  input  wire        conv_fault_reset,
  input  wire        wdog_reset,
  output reg         converters_enable,
  output reg         ldo1_enable,
  output reg         backup_regulator_enable,
  output reg         oscillator_rtc_enable,
  output reg         trickle_charge_enable,
  output reg         fast_charge_allow,
  output reg         run_on_usb,
  output reg         defaults_restore,
  output reg         wake_summary_irq,
  output reg  [5:0]  power_state
);
  // One-hot operating states
  localparam [5:0] ST_ZERO = 6'h01;
  localparam [5:0] ST_BACKUP = 6'h02;
  localparam [5:0] ST_OFF = 6'h04;
  localparam [5:0] ST_PRE = 6'h08;
  localparam [5:0] ST_ACTIVE = 6'h10;
  localparam [5:0] ST_HIB = 6'h20;

  reg  [5:0]  state_q;
  reg  [5:0]  state_d;
  reg         hib_req_q;
  reg  [15:0] config_q;
  reg  [6:0]  wake_status_q;
  reg  [6:0]  wake_mask_q;
  reg         seq_fault_q;
  reg         from_hib_q;
  reg         usb_start_q;
  reg         key_q_prev;
  reg         wake_q_prev;
  reg         pwrup_q_prev;
  reg         hib_edge_prev;
  reg         hib_edge_hold_q;
  reg         conv_prev;
  reg         wdog_prev;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         aw_have_q;
  reg         w_have_q;
  wire        key_qual;
  wire        wake_qual;
  wire        pwrup_qual;
  wire        key_lvl;
  wire        wake_lvl;
  wire        pwrup_lvl;
  wire        key_rise;
  wire        wake_rise;
  wire        pwrup_rise;
  wire        hib_edge_rise;
  wire        supply_ok;
  wire        startup_event;
  wire        wake_event;
  wire        do_write;
  wire        do_read;
  wire        status_read;
  wire [6:0]  wake_set;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;

  // Polarity selection of the qualified inputs
  assign key_lvl   = power_key_in ^ ~config_q[`CFG_KEY_POL_BIT];
  assign wake_lvl  = wake_request_gpio ^ ~config_q[`CFG_WAKE_POL_BIT];
  assign pwrup_lvl = power_up_request_input ^ ~config_q[`CFG_PWRUP_POL_BIT];

  qual_timer u_key (.aclk(aclk), .aresetn(aresetn), .slow_tick(slow_tick), .level(key_lvl), .qualified(key_qual));
  qual_timer u_wake (.aclk(aclk), .aresetn(aresetn), .slow_tick(slow_tick), .level(wake_lvl), .qualified(wake_qual));
  qual_timer u_pwrup (.aclk(aclk), .aresetn(aresetn), .slow_tick(slow_tick), .level(pwrup_lvl), .qualified(pwrup_qual));

  // Edges of qualified inputs and the hibernate edge pin
  assign key_rise      = key_qual & ~key_q_prev;
  assign wake_rise     = wake_qual & ~wake_q_prev;
  assign pwrup_rise    = pwrup_qual & ~pwrup_q_prev;
  assign hib_edge_rise = hibernate_edge_gpio & ~hib_edge_prev;

  // Start-up events gated by line threshold; battery presence is no event
  assign supply_ok     = line_level > config_q[`CFG_THR_MSB:`CFG_THR_LSB];
  assign startup_event = supply_ok & (key_rise | wake_rise | pwrup_rise
                         | (rtc_alarm & config_q[`CFG_ALARM_EN_BIT])
                         | adaptor_sense_above_4v0
                         | usb_above_4v0);
  assign wake_event    = startup_event;

  // Next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_ZERO: begin
        if (backup_supply_rail_ok)
          state_d = line_above_uvlo ? ST_OFF : ST_BACKUP;
      end
      ST_BACKUP: begin
        if (line_above_uvlo)
          state_d = ST_OFF;
        else if (!backup_supply_rail_ok)
          state_d = ST_ZERO;
      end
      ST_OFF: begin
        if (!line_above_uvlo && backup_supply_rail_ok)
          state_d = ST_BACKUP;
        else if (!line_above_uvlo)
          state_d = ST_ZERO;
        else if (startup_event)
          state_d = ST_PRE;
      end
      ST_PRE: begin
        if (fault_detected || seq_fault_q)
          state_d = ST_OFF;
        else if (startup_seq_done && (!config_q[`CFG_DEV_MODE_BIT] || startup_trigger))
          state_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (shutdown_event || line_below_shutdown)
          state_d = ST_OFF;
        else if (hib_req_q || hib_edge_rise || hibernate_level_gpio)
          state_d = ST_HIB;
      end
      ST_HIB: begin
        if (fault_detected || shutdown_event)
          state_d = ST_OFF;
        else if (hib_edge_rise || wake_event || (!hibernate_level_gpio && !hib_req_q && !hib_edge_hold_q))
          state_d = ST_PRE;
      end
      default: state_d = ST_ZERO;
    endcase
  end

  // AXI write and read handshakes
  assign wr_addr     = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : awaddr_q;
  assign wr_data     = s_axi_wvalid && s_axi_wready ? s_axi_wdata : wdata_q;
  assign wr_strb     = s_axi_wvalid && s_axi_wready ? s_axi_wstrb : wstrb_q;
  assign do_write    = (aw_have_q || (s_axi_awvalid && s_axi_awready))
                       && (w_have_q || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
  assign do_read     = s_axi_arvalid && s_axi_arready;
  assign status_read = do_read && s_axi_araddr == `ADDR_WAKE_STATUS;

  // Wake cause set terms: OFF and HIB on the pre-active to active step, the others on rising edges
  assign wake_set[`WC_OFF]   = state_q == ST_PRE && state_d == ST_ACTIVE && !from_hib_q;
  assign wake_set[`WC_HIB]   = state_q == ST_PRE && state_d == ST_ACTIVE && from_hib_q;
  assign wake_set[`WC_CONV]  = conv_fault_reset & ~conv_prev;
  assign wake_set[`WC_WDOG]  = wdog_reset & ~wdog_prev;
  assign wake_set[`WC_PWRUP] = pwrup_rise;
  assign wake_set[`WC_KEY]   = key_rise;
  assign wake_set[`WC_WAKE]  = wake_rise;

  // State, flags and registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q       <= ST_OFF;
      hib_req_q     <= 1'b0;
      config_q      <= `RST_CONFIG;
      wake_status_q <= 7'h00;
      wake_mask_q   <= `RST_MASK;
      seq_fault_q   <= 1'b0;
      from_hib_q    <= 1'b0;
      usb_start_q   <= 1'b0;
      key_q_prev    <= 1'b0;
      wake_q_prev   <= 1'b0;
      pwrup_q_prev  <= 1'b0;
      hib_edge_prev <= 1'b0;
      hib_edge_hold_q <= 1'b0;
      conv_prev     <= 1'b0;
      wdog_prev     <= 1'b0;
    end else begin
      state_q       <= state_d;
      key_q_prev    <= key_qual;
      wake_q_prev   <= wake_qual;
      pwrup_q_prev  <= pwrup_qual;
      hib_edge_prev <= hibernate_edge_gpio;
      conv_prev     <= conv_fault_reset;
      wdog_prev     <= wdog_reset;
      if (state_q == ST_ACTIVE)
        hib_edge_hold_q <= hib_edge_rise;
      if (state_q == ST_PRE)
        seq_fault_q <= seq_fault_q | fault_detected;
      else
        seq_fault_q <= 1'b0;
      if (state_d == ST_PRE && state_q != ST_PRE) begin
        from_hib_q  <= state_q == ST_HIB;
        usb_start_q <= usb_above_4v0;
      end
      // Set wins over clear-on-read
      wake_status_q <= (status_read ? 7'h00 : wake_status_q) | wake_set;
      if (do_write && wr_addr == `ADDR_STATE_SELECT && wr_strb[1])
        hib_req_q <= wr_data[`HIB_REQ_BIT];
      if (do_write && wr_addr == `ADDR_CONFIG) begin
        if (wr_strb[0])
          config_q[7:0] <= wr_data[7:0];
        if (wr_strb[1])
          config_q[15:8] <= wr_data[15:8];
      end
      if (do_write && wr_addr == `ADDR_WAKE_MASK && wr_strb[0])
        wake_mask_q <= wr_data[6:0];
      // Defaults restored on entry to OFF and while going to or staying in ZERO
      if (state_d == ST_OFF && state_q != ST_OFF || state_d == ST_ZERO) begin
        hib_req_q   <= 1'b0;
        config_q    <= `RST_CONFIG;
        wake_mask_q <= `RST_MASK;
        if (state_d == ST_ZERO)
          wake_status_q <= 7'h00;
      end
    end
  end

  // AXI slave channel handling
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h00000000;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (wr_addr == `ADDR_STATE_SELECT || wr_addr == `ADDR_CONFIG
                          || wr_addr == `ADDR_WAKE_MASK || wr_addr == `ADDR_WAKE_STATUS
                          || wr_addr == `ADDR_STATE || wr_addr == `ADDR_SUPPLY) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `ADDR_STATE_SELECT: s_axi_rdata <= {16'h0000, hib_req_q, 15'h0};
          `ADDR_CONFIG:       s_axi_rdata <= {16'h0000, config_q};
          `ADDR_WAKE_STATUS:  s_axi_rdata <= {25'h0, wake_status_q};
          `ADDR_WAKE_MASK:    s_axi_rdata <= {25'h0, wake_mask_q};
          `ADDR_STATE:        s_axi_rdata <= {26'h0, state_q};
          `ADDR_SUPPLY:       s_axi_rdata <= {27'h0, supply_ok, line_level};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Supply and charger controls per state
  always @(posedge aclk) begin
    if (!aresetn) begin
      converters_enable       <= 1'b0;
      ldo1_enable             <= 1'b0;
      backup_regulator_enable <= 1'b1;
      oscillator_rtc_enable   <= 1'b1;
      trickle_charge_enable   <= 1'b1;
      fast_charge_allow       <= 1'b0;
      run_on_usb              <= 1'b0;
      defaults_restore        <= 1'b0;
      wake_summary_irq        <= 1'b0;
      power_state             <= ST_OFF;
    end else begin
      power_state             <= state_q;
      converters_enable       <= state_q == ST_ACTIVE || state_q == ST_HIB;
      ldo1_enable             <= state_q == ST_ACTIVE || state_q == ST_HIB || state_q == ST_OFF;
      backup_regulator_enable <= state_q != ST_ZERO && state_q != ST_BACKUP;
      oscillator_rtc_enable   <= state_q != ST_ZERO;
      trickle_charge_enable   <= state_q == ST_OFF || state_q == ST_HIB
                                 || (state_q == ST_ACTIVE && usb_start_q && !config_q[`CFG_SUSPEND_BIT]);
      fast_charge_allow       <= state_q == ST_ACTIVE;
      run_on_usb              <= (state_q == ST_ACTIVE || state_q == ST_PRE) && usb_start_q
                                 && !config_q[`CFG_SUSPEND_BIT];
      defaults_restore        <= state_d == ST_OFF && state_q != ST_OFF;
      wake_summary_irq        <= |(wake_status_q & ~wake_mask_q);
    end
  end
endmodule

`default_nettype wire

// ### hdl/power_state_map.vh
// Register map, field positions, reset values and timing counts for the power state controller
`ifndef POWER_STATE_MAP_VH
`define POWER_STATE_MAP_VH
// Byte addresses: register index 0x05 is not word aligned, so byte = 4 * index
`define IDX_STATE_SELECT      8'h05
`define ADDR_STATE_SELECT     8'h14
`define ADDR_WAKE_STATUS      8'h7c
`define ADDR_WAKE_MASK        8'h9c
`define ADDR_CONFIG           8'h20
`define ADDR_STATE            8'h24
`define ADDR_SUPPLY           8'h28
// Field positions
`define HIB_REQ_BIT           15
`define CFG_KEY_POL_BIT       0
`define CFG_WAKE_POL_BIT      1
`define CFG_PWRUP_POL_BIT     2
`define CFG_ALARM_EN_BIT      3
`define CFG_DEV_MODE_BIT      4
`define CFG_SUSPEND_BIT       5
`define CFG_THR_LSB           8
`define CFG_THR_MSB           11
// Wake cause bit positions
`define WC_OFF                6
`define WC_HIB                5
`define WC_CONV               4
`define WC_WDOG               3
`define WC_PWRUP              2
`define WC_KEY                1
`define WC_WAKE               0
// Reset values
`define RST_CONFIG            16'h0300
`define RST_MASK              7'h00
// Qualification time: 40 ms at 32768 Hz slow clock ticks
`define QUAL_TIME_MS          40
`define SLOW_CLK_HZ           32768
`define QUAL_TICKS            ((`QUAL_TIME_MS * `SLOW_CLK_HZ + 999) / 1000)
`define QUAL_CNT_W            11
`endif

// ### test/host_model.sv
// Host processor model: AXI4-Lite master reading and writing the registers
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        aclk,
  output logic      [7:0]  awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic      [31:0] wdata,
  output logic      [3:0]  wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic      [7:0]  araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus at time zero
  initial begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
  end

  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // Read of any register word, taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/power_state_controller_tb.sv
// Self-checking bench for the power state controller
`timescale 1ns/1ps
`default_nettype none
`include "power_state_map.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module power_state_controller_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        tick, key, wake, pwrup, hedge, hlvl, alarm, adp, usb, uvlo, bsd, brail, sd, flt, done, trig;
  logic        cfr, wdr, cen, l1, bke, osc, trk, fst, ousb, rst, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, line;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  ps;
  int          bad_count, total_checks, cyc, n;

  power_state_controller dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slow_tick(tick), .power_key_in(key), .wake_request_gpio(wake),
    .power_up_request_input(pwrup), .hibernate_edge_gpio(hedge), .hibernate_level_gpio(hlvl), .rtc_alarm(alarm),
    .adaptor_sense_above_4v0(adp), .usb_above_4v0(usb), .line_level(line), .line_above_uvlo(uvlo),
    .line_below_shutdown(bsd), .backup_supply_rail_ok(brail), .shutdown_event(sd), .fault_detected(flt),
    .startup_seq_done(done), .startup_trigger(trig), .conv_fault_reset(cfr), .wdog_reset(wdr),
    .converters_enable(cen), .ldo1_enable(l1), .backup_regulator_enable(bke), .oscillator_rtc_enable(osc),
    .trickle_charge_enable(trk), .fast_charge_allow(fst), .run_on_usb(ousb), .defaults_restore(rst),
    .wake_summary_irq(irq), .power_state(ps));
  host_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  // Expected wake cause word
  function automatic logic [31:0] cause(input logic off_b, input logic hib_b, input logic pwr_b, input logic key_b);
    cause = 32'h0;
    cause[`WC_OFF] = off_b;
    cause[`WC_HIB] = hib_b;
    cause[`WC_PWRUP] = pwr_b;
    cause[`WC_KEY] = key_b;
  endfunction

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host_u.rd(a, d, r);
    `CHK({r, d}, {2'b00, e})
  endtask

  // Wait a bounded time for a state code
  task automatic wst(input logic [5:0] e);
    n = 0;
    while (ps !== e && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    `CHK(ps, e)
  endtask

  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    {aresetn, tick, hedge, hlvl, alarm, adp, usb, bsd, sd, flt, trig, cfr, wdr} = '0;
    {key, wake, pwrup, uvlo, brail, done} = '1;
    line = 4'h0;
    n = $urandom(83);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    tick    <= 1'b1;
    // Reset values, random mask, unmapped place
    `CHK(ps, 6'h04)
    rd(`ADDR_CONFIG, `RST_CONFIG);
    rd(`ADDR_WAKE_MASK, `RST_MASK);
    host_u.rd(8'h40, d, r);
    `CHK({r, d}, {2'b10, 32'h0})
    host_u.wr(8'h40, 32'h1, r);
    `CHK(r, 2'b10)
    d = $urandom & 32'h7f;
    host_u.wr(`ADDR_WAKE_MASK, d, r);
    rd(`ADDR_WAKE_MASK, d);
    host_u.wr(`ADDR_WAKE_MASK, 32'h0, r);
    // Key held while the line is under the start threshold
    key <= 1'b0;
    repeat (1400) @(posedge aclk);
    `CHK(ps, 6'h04)
    key  <= 1'b1;
    line <= 4'h8;
    // Short press restarts the count, long press starts up
    @(posedge aclk);
    key <= 1'b0;
    repeat (100 + $urandom % 900) @(posedge aclk);
    key <= 1'b1;
    @(posedge aclk);
    key <= 1'b0;
    wst(6'h10);
    `CHK(n >= `QUAL_TICKS, 1'b1)
    key <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    rd(`ADDR_WAKE_STATUS, cause(1, 0, 0, 1));
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(`ADDR_WAKE_STATUS, 32'h0);
    // Software hibernate request and release
    host_u.wr(`ADDR_STATE_SELECT, 32'h1 << `HIB_REQ_BIT, r);
    wst(6'h20);
    `CHK(fst, 1'b0)
    host_u.wr(`ADDR_STATE_SELECT, 32'h0, r);
    wst(6'h10);
    rd(`ADDR_WAKE_STATUS, cause(0, 1, 0, 0));
    // Level pin hibernate, then a fault while hibernating
    host_u.wr(`ADDR_CONFIG, 32'h8, r);
    hlvl <= 1'b1;
    wst(6'h20);
    flt <= 1'b1;
    wst(6'h04);
    {flt, hlvl} <= 2'b00;
    `CHK(cen, 1'b0)
    rd(`ADDR_CONFIG, `RST_CONFIG);
    // Enabled alarm starts up, shutdown event stops
    host_u.wr(`ADDR_CONFIG, 32'h0308, r);
    alarm <= 1'b1;
    wst(6'h10);
    alarm <= 1'b0;
    rd(`ADDR_WAKE_STATUS, cause(1, 0, 0, 0));
    sd <= 1'b1;
    wst(6'h04);
    sd <= 1'b0;
    // Development mode waits for the trigger in pre-active
    pwrup <= 1'b0;
    host_u.wr(`ADDR_CONFIG, 32'h0314, r);
    pwrup <= 1'b1;
    wst(6'h08);
    repeat (50) @(posedge aclk);
    `CHK(ps, 6'h08)
    trig <= 1'b1;
    wst(6'h10);
    trig <= 1'b0;
    rd(`ADDR_WAKE_STATUS, cause(1, 0, 1, 0));
    // Supply loss: backup, back to off, then zero
    sd <= 1'b1;
    wst(6'h04);
    sd   <= 1'b0;
    uvlo <= 1'b0;
    wst(6'h02);
    uvlo <= 1'b1;
    wst(6'h04);
    uvlo <= 1'b0;
    wst(6'h02);
    brail <= 1'b0;
    wst(6'h01);
    {uvlo, brail, aresetn} <= 3'b110;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // USB plug-in without suspend, then adaptor plug-in
    usb <= 1'b1;
    wst(6'h10);
    repeat (2) @(posedge aclk);
    `CHK({ousb, trk}, 2'b11)
    usb <= 1'b0;
    sd  <= 1'b1;
    wst(6'h04);
    sd  <= 1'b0;
    adp <= 1'b1;
    wst(6'h10);
    rd(`ADDR_WAKE_STATUS, cause(1, 0, 0, 0));
    // Masked reset causes, edge hibernate, wake pin start-up
    host_u.wr(`ADDR_WAKE_MASK, 32'h18, r);
    {cfr, wdr, adp} <= 3'b110;
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(`ADDR_WAKE_STATUS, (32'h1 << `WC_CONV) | (32'h1 << `WC_WDOG));
    {cfr, wdr, hedge} <= 3'b001;
    wst(6'h20);
    hedge <= 1'b0;
    repeat (20) @(posedge aclk);
    `CHK(ps, 6'h20)
    hedge <= 1'b1;
    wst(6'h10);
    rd(`ADDR_WAKE_STATUS, cause(0, 1, 0, 0));
    {sd, hedge} <= 2'b10;
    wst(6'h04);
    {sd, wake} <= 2'b00;
    wst(6'h10);
    rd(`ADDR_WAKE_STATUS, cause(1, 0, 0, 0) | (32'h1 << `WC_WAKE));
    complete_run();
  end
endmodule
`default_nettype wire

// ### test/power_state_monitor.sv
// Checker for the power state and supply outputs of the controller
`timescale 1ns/1ps
`default_nettype none
module power_state_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [5:0] power_state,
  input wire logic       converters_enable,
  input wire logic       ldo1_enable,
  input wire logic       backup_regulator_enable,
  input wire logic       oscillator_rtc_enable,
  input wire logic       trickle_charge_enable,
  input wire logic       fast_charge_allow,
  input wire logic       defaults_restore
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Exactly one state shown at a time
  state_onehot_a: assert property (
    $onehot(power_state)) else $error("state code not one-hot");
  active_via_pre_a: assert property (
    $rose(power_state[4]) |-> $past(power_state[3])) else $error("active entered not from pre-active");
  hib_from_active_a: assert property (
    $rose(power_state[5]) |-> $past(power_state[4])) else $error("hibernate entered not from active");
  backup_from_off_a: assert property (
    $rose(power_state[1]) |-> $past(power_state[2])) else $error("backup entered not from off");
  // Settled states and their supply outputs, and the restore pulse at off entry
  off_power_down_a: assert property (
    power_state[2] && $past(power_state[2]) |-> !converters_enable && backup_regulator_enable)
    else $error("off state supplies wrong");
  off_trickle_on_a: assert property (
    power_state[2] && $past(power_state[2]) |-> trickle_charge_enable) else $error("off without trickle");
  restore_in_off_a: assert property (
    defaults_restore |-> ##[0:2] power_state[2]) else $error("restore pulse outside off entry");
  hib_no_fast_a: assert property (
    power_state[5] && $past(power_state[5]) |-> !fast_charge_allow) else $error("fast charge in hibernate");
  backup_outputs_a: assert property (
    power_state[1] && $past(power_state[1]) |-> oscillator_rtc_enable && !converters_enable && !ldo1_enable)
    else $error("backup state outputs wrong");
  zero_outputs_a: assert property (
    power_state[0] && $past(power_state[0]) |-> !converters_enable && !oscillator_rtc_enable)
    else $error("zero state outputs wrong");
endmodule
bind power_state_controller power_state_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
  .power_state(power_state), .converters_enable(converters_enable), .ldo1_enable(ldo1_enable),
  .backup_regulator_enable(backup_regulator_enable), .oscillator_rtc_enable(oscillator_rtc_enable),
  .trickle_charge_enable(trickle_charge_enable), .fast_charge_allow(fast_charge_allow),
  .defaults_restore(defaults_restore));
`default_nettype wire
